// >>> ext_cap_pkg.sv
/*
 * Constants for the extended-capability register bank: byte offsets,
 * field positions, reset values and fixed identifier fields.
 * Assumes a 12-bit configuration byte address and 32-bit data.
 */
package ext_cap_pkg;
	// register byte offsets
	localparam logic [11:0] CORR_STATUS_OFF = 12'h110;
	localparam logic [11:0] CORR_MASK_OFF   = 12'h114;
	localparam logic [11:0] ERR_CTL_OFF     = 12'h118;
	localparam logic [11:0] HDR_LOG1_OFF    = 12'h11C;
	localparam logic [11:0] HDR_LOG2_OFF    = 12'h120;
	localparam logic [11:0] HDR_LOG3_OFF    = 12'h124;
	localparam logic [11:0] HDR_LOG4_OFF    = 12'h128;
	localparam logic [11:0] LOG_CTL_OFF     = 12'h130;
	localparam logic [11:0] SER_CAP_OFF     = 12'h180;
	localparam logic [11:0] SER_LO_OFF      = 12'h184;
	localparam logic [11:0] SER_HI_OFF      = 12'h188;
	localparam logic [11:0] VC_CAP_OFF      = 12'h200;
	// correctable event bit positions in status and mask
	localparam int RX_ERR_POS   = 0;
	localparam int BAD_TLP_POS  = 6;
	localparam int BAD_DLLP_POS = 7;
	localparam int RPL_ROLL_POS = 8;
	localparam int RPL_TO_POS   = 12;
	localparam int ADV_NF_POS   = 13;
	localparam logic [31:0] CORR_BITS     = 32'h0000_31C1;
	localparam logic [31:0] CORR_MASK_RST = 32'h0000_2000;
	// error control fields
	localparam int FEP_LSB      = 0;
	localparam int GEN_CAP_POS  = 5;
	localparam int GEN_EN_POS   = 6;
	localparam int CHK_CAP_POS  = 7;
	localparam int CHK_EN_POS   = 8;
	localparam logic GEN_CAP_RST = 1'b1;
	localparam logic CHK_CAP_RST = 1'b1;
	// capability header fields
	localparam int CAP_VER_LSB = 16;
	localparam int NEXT_PTR_LSB = 20;
	localparam logic [15:0] SER_CAP_ID  = 16'h0003;
	localparam logic [15:0] VC_CAP_ID   = 16'h0002;
	localparam logic [3:0]  CAP_VERSION = 4'h1;
	localparam logic [11:0] SER_NEXT_RST = 12'h200;
	localparam logic [11:0] VC_NEXT_RST  = 12'h000;
	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// >>> ext_cap_regs.sv
/*
 * Extended-capability register bank of one switch port: correctable
 * error status and mask, error control, header log, serial number and
 * virtual channel capability headers, behind an AXI4-Lite slave.
 * Assumes event, header and unlock inputs come from logic on aclk.
 * aresetn is the power-on reset; port_reset restores non-sticky fields to their reset values.
 */
`timescale 1ns/1ps
module ext_cap_regs (
	// clock and resets
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        port_reset,
	// axi4-lite write address and data
	input  wire logic [11:0] awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	// axi4-lite write response
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	// axi4-lite read
	input  wire logic [11:0] araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	// correctable events: rx, bad tlp, bad dllp, rollover, timeout, advisory
	input  wire logic [5:0]  corr_evt,
	// first uncorrectable error with its header
	input  wire logic        ue_valid,
	input  wire logic [4:0]  ue_bit,
	input  wire logic [31:0] ue_hdr1,
	input  wire logic [31:0] ue_hdr2,
	input  wire logic [31:0] ue_hdr3,
	input  wire logic [31:0] ue_hdr4,
	// opens lockable fields, e.g. during configuration loading
	input  wire logic        cfg_unlock,
	// upstream report and datapath controls
	output logic             corr_report,
	output logic [31:0]      corr_report_bits,
	output logic             ecrc_gen_on,
	output logic             ecrc_chk_on
);
	logic        awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0]  bresp_q, rresp_q;
	logic [31:0] rdata_q;
	logic        aw_have_q, w_have_q;
	logic [11:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	logic        aw_take, w_take, ar_take, wr_fire;
	logic [31:0] wmask, evt_vec;
	logic [31:0] status_q, mask_q;
	logic [4:0]  first_error_pointer_q;
	logic        ecrc_gen_capable_q, ecrc_gen_enable_q;
	logic        ecrc_check_capable_q, ecrc_check_enable_q;
	logic [31:0] header_log_word_q [4];
	logic        log_held_q;
	logic [11:0] ser_next_q, vc_next_q;
	logic [31:0] serial_number_word_q [2];
	logic        report_q;
	logic [31:0] report_bits_q;
	logic [31:0] rd_word;
	logic        rd_hit, wr_hit;

	// outputs straight from flops
	assign awready          = awready_q;
	assign wready           = wready_q;
	assign bvalid           = bvalid_q;
	assign bresp            = bresp_q;
	assign arready          = arready_q;
	assign rvalid           = rvalid_q;
	assign rdata            = rdata_q;
	assign rresp            = rresp_q;
	assign corr_report      = report_q;
	assign corr_report_bits = report_bits_q;
	assign ecrc_gen_on      = ecrc_gen_enable_q;
	assign ecrc_chk_on      = ecrc_check_enable_q;

	// handshakes
	assign aw_take = awvalid & awready_q;
	assign w_take  = wvalid & wready_q;
	assign ar_take = arvalid & arready_q;
	assign wr_fire = aw_have_q & w_have_q & ~bvalid_q;
	assign wmask   = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
		{8{w_strb_q[1]}}, {8{w_strb_q[0]}}};

	// spread the six event inputs onto their status positions
	always_comb
	begin
		evt_vec                           = 32'h0000_0000;
		evt_vec[ext_cap_pkg::RX_ERR_POS]   = corr_evt[0];
		evt_vec[ext_cap_pkg::BAD_TLP_POS]  = corr_evt[1];
		evt_vec[ext_cap_pkg::BAD_DLLP_POS] = corr_evt[2];
		evt_vec[ext_cap_pkg::RPL_ROLL_POS] = corr_evt[3];
		evt_vec[ext_cap_pkg::RPL_TO_POS]   = corr_evt[4];
		evt_vec[ext_cap_pkg::ADV_NF_POS]   = corr_evt[5];
	end

	// write address channel, held until the write is done
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_have_q <= 1'b0;
			awready_q <= 1'b0;
			aw_addr_q <= 12'h000;
		end
		else if (aw_take)
		begin
			aw_have_q <= 1'b1;
			awready_q <= 1'b0;
			aw_addr_q <= awaddr;
		end
		else if (wr_fire)
		begin
			aw_have_q <= 1'b0;
			awready_q <= 1'b1;
		end
		else if (!aw_have_q)
			awready_q <= 1'b1;
	end

	// write data channel, taken independently of the address
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			w_have_q <= 1'b0;
			wready_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
		end
		else if (w_take)
		begin
			w_have_q <= 1'b1;
			wready_q <= 1'b0;
			w_data_q <= wdata;
			w_strb_q <= wstrb;
		end
		else if (wr_fire)
		begin
			w_have_q <= 1'b0;
			wready_q <= 1'b1;
		end
		else if (!w_have_q)
			wready_q <= 1'b1;
	end

	// write decode: any mapped offset answers okay
	always_comb
	begin
		unique case (aw_addr_q)
			ext_cap_pkg::CORR_STATUS_OFF, ext_cap_pkg::CORR_MASK_OFF,
			ext_cap_pkg::ERR_CTL_OFF, ext_cap_pkg::HDR_LOG1_OFF,
			ext_cap_pkg::HDR_LOG2_OFF, ext_cap_pkg::HDR_LOG3_OFF,
			ext_cap_pkg::HDR_LOG4_OFF, ext_cap_pkg::LOG_CTL_OFF,
			ext_cap_pkg::SER_CAP_OFF, ext_cap_pkg::SER_LO_OFF,
			ext_cap_pkg::SER_HI_OFF, ext_cap_pkg::VC_CAP_OFF: wr_hit = 1'b1;
			default: wr_hit = 1'b0;
		endcase
	end

	// write response
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			bvalid_q <= 1'b0;
			bresp_q  <= ext_cap_pkg::RESP_OKAY;
		end
		else if (wr_fire)
		begin
			bvalid_q <= 1'b1;
			bresp_q  <= wr_hit ? ext_cap_pkg::RESP_OKAY : ext_cap_pkg::RESP_SLVERR;
		end
		else if (bready)
			bvalid_q <= 1'b0;
	end

	// correctable status: event set wins over write-one-clear
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			status_q <= 32'h0000_0000;
		else if (wr_fire && aw_addr_q == ext_cap_pkg::CORR_STATUS_OFF)
			status_q <= ((status_q & ~(w_data_q & wmask)) | evt_vec)
				& ext_cap_pkg::CORR_BITS;
		else
			status_q <= status_q | evt_vec;
	end

	// correctable mask, sticky across port reset
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			mask_q <= ext_cap_pkg::CORR_MASK_RST;
		else if (wr_fire && aw_addr_q == ext_cap_pkg::CORR_MASK_OFF)
			mask_q <= ((mask_q & ~wmask) | (w_data_q & wmask))
				& ext_cap_pkg::CORR_BITS;
	end

	// upstream report carries only unmasked events
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			report_q      <= 1'b0;
			report_bits_q <= 32'h0000_0000;
		end
		else
		begin
			report_q      <= |(evt_vec & ~mask_q);
			report_bits_q <= evt_vec & ~mask_q;
		end
	end

	// sticky ecrc enables
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ecrc_gen_enable_q   <= 1'b0;
			ecrc_check_enable_q <= 1'b0;
		end
		else if (wr_fire && aw_addr_q == ext_cap_pkg::ERR_CTL_OFF && w_strb_q[0])
			ecrc_gen_enable_q <= w_data_q[ext_cap_pkg::GEN_EN_POS];
		if (aresetn && wr_fire && aw_addr_q == ext_cap_pkg::ERR_CTL_OFF && w_strb_q[1])
			ecrc_check_enable_q <= w_data_q[ext_cap_pkg::CHK_EN_POS];
	end

	// lockable, non-sticky capability bits and next pointers
	always_ff @(posedge aclk)
	begin
		if (!aresetn || port_reset)
		begin
			ecrc_gen_capable_q   <= ext_cap_pkg::GEN_CAP_RST;
			ecrc_check_capable_q <= ext_cap_pkg::CHK_CAP_RST;
			ser_next_q           <= ext_cap_pkg::SER_NEXT_RST;
			vc_next_q            <= ext_cap_pkg::VC_NEXT_RST;
		end
		else if (wr_fire && cfg_unlock)
		begin
			if (aw_addr_q == ext_cap_pkg::ERR_CTL_OFF && w_strb_q[0])
				ecrc_gen_capable_q <= w_data_q[ext_cap_pkg::GEN_CAP_POS];
			if (aw_addr_q == ext_cap_pkg::ERR_CTL_OFF && w_strb_q[0])
				ecrc_check_capable_q <= w_data_q[ext_cap_pkg::CHK_CAP_POS];
			if (aw_addr_q == ext_cap_pkg::SER_CAP_OFF && (&w_strb_q[3:2]))
				ser_next_q <= w_data_q[31:ext_cap_pkg::NEXT_PTR_LSB];
			if (aw_addr_q == ext_cap_pkg::VC_CAP_OFF && (&w_strb_q[3:2]))
				vc_next_q <= w_data_q[31:ext_cap_pkg::NEXT_PTR_LSB];
		end
	end

	// serial number words, lockable and sticky
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			serial_number_word_q[0] <= 32'h0000_0000;
			serial_number_word_q[1] <= 32'h0000_0000;
		end
		else if (wr_fire && cfg_unlock)
		begin
			if (aw_addr_q == ext_cap_pkg::SER_LO_OFF)
				serial_number_word_q[0] <= (serial_number_word_q[0] & ~wmask)
					| (w_data_q & wmask);
			if (aw_addr_q == ext_cap_pkg::SER_HI_OFF)
				serial_number_word_q[1] <= (serial_number_word_q[1] & ~wmask)
					| (w_data_q & wmask);
		end
	end

	// first uncorrectable error capture; release by writing one to log control
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			log_held_q            <= 1'b0;
			first_error_pointer_q <= 5'h00;
			for (int i = 0; i < 4; i++)
				header_log_word_q[i] <= 32'h0000_0000;
		end
		else if (ue_valid && !log_held_q)
		begin
			log_held_q            <= 1'b1; // release wins over capture; an error in the release cycle is lost
			first_error_pointer_q <= ue_bit;
			header_log_word_q[0]  <= ue_hdr1;
			header_log_word_q[1]  <= ue_hdr2;
			header_log_word_q[2]  <= ue_hdr3;
			header_log_word_q[3]  <= ue_hdr4;
		end
		else if (wr_fire && aw_addr_q == ext_cap_pkg::LOG_CTL_OFF && w_strb_q[0]
			&& w_data_q[0])
			log_held_q <= 1'b0;
	end

	// read mux; reserved bits stay zero
	always_comb
	begin
		rd_word = 32'h0000_0000;
		rd_hit  = 1'b1;
		unique case (araddr)
			ext_cap_pkg::CORR_STATUS_OFF: rd_word = status_q;
			ext_cap_pkg::CORR_MASK_OFF:   rd_word = mask_q;
			ext_cap_pkg::ERR_CTL_OFF:
			begin
				rd_word[ext_cap_pkg::FEP_LSB +: 5]  = first_error_pointer_q;
				rd_word[ext_cap_pkg::GEN_CAP_POS]   = ecrc_gen_capable_q;
				rd_word[ext_cap_pkg::GEN_EN_POS]    = ecrc_gen_enable_q;
				rd_word[ext_cap_pkg::CHK_CAP_POS]   = ecrc_check_capable_q;
				rd_word[ext_cap_pkg::CHK_EN_POS]    = ecrc_check_enable_q;
			end
			ext_cap_pkg::HDR_LOG1_OFF: rd_word = header_log_word_q[0];
			ext_cap_pkg::HDR_LOG2_OFF: rd_word = header_log_word_q[1];
			ext_cap_pkg::HDR_LOG3_OFF: rd_word = header_log_word_q[2];
			ext_cap_pkg::HDR_LOG4_OFF: rd_word = header_log_word_q[3];
			ext_cap_pkg::LOG_CTL_OFF:  rd_word[0] = log_held_q;
			ext_cap_pkg::SER_CAP_OFF:
				rd_word = {ser_next_q, ext_cap_pkg::CAP_VERSION,
					ext_cap_pkg::SER_CAP_ID};
			ext_cap_pkg::SER_LO_OFF: rd_word = serial_number_word_q[0];
			ext_cap_pkg::SER_HI_OFF: rd_word = serial_number_word_q[1];
			ext_cap_pkg::VC_CAP_OFF:
				rd_word = {vc_next_q, ext_cap_pkg::CAP_VERSION,
					ext_cap_pkg::VC_CAP_ID};
			default: rd_hit = 1'b0;
		endcase
	end

	// read channel: one read at a time, answered the cycle after it is taken
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b0;
			rdata_q   <= 32'h0000_0000;
			rresp_q   <= ext_cap_pkg::RESP_OKAY;
		end
		else if (ar_take)
		begin
			arready_q <= 1'b0;
			rvalid_q  <= 1'b1;
			rdata_q   <= rd_word;
			rresp_q   <= rd_hit ? ext_cap_pkg::RESP_OKAY : ext_cap_pkg::RESP_SLVERR;
		end
		else if (rvalid_q && rready)
			rvalid_q <= 1'b0;
		else if (!rvalid_q)
			arready_q <= 1'b1;
	end

	// assertions
	sequence s_mask_write;
		wr_fire && aw_addr_q == ext_cap_pkg::CORR_MASK_OFF && (&w_strb_q);
	endsequence

	sequence s_first_capture;
		ue_valid && !log_held_q;
	endsequence

	property p_mask_reset;
		@(posedge aclk) $rose(aresetn) |-> mask_q == ext_cap_pkg::CORR_MASK_RST;
	endproperty
	a_mask_reset: assert property (p_mask_reset)
		else $error("mask reset value wrong");

	property p_mask_write;
		@(posedge aclk) disable iff (!aresetn)
		s_mask_write |=> mask_q == ($past(w_data_q) & ext_cap_pkg::CORR_BITS);
	endproperty
	a_mask_write: assert property (p_mask_write)
		else $error("mask write not stored");

	property p_masked_silent;
		@(posedge aclk) disable iff (!aresetn)
		1'b1 |=> (report_bits_q & $past(mask_q)) == 32'h0000_0000;
	endproperty
	a_masked_silent: assert property (p_masked_silent)
		else $error("masked event reported");

	property p_unmasked_report;
		@(posedge aclk) disable iff (!aresetn)
		corr_evt[1] && !mask_q[ext_cap_pkg::BAD_TLP_POS]
		|=> report_q && report_bits_q[ext_cap_pkg::BAD_TLP_POS];
	endproperty
	a_unmasked_report: assert property (p_unmasked_report)
		else $error("unmasked event not reported");

	property p_status_set;
		@(posedge aclk) disable iff (!aresetn)
		corr_evt[3] |=> status_q[ext_cap_pkg::RPL_ROLL_POS];
	endproperty
	a_status_set: assert property (p_status_set)
		else $error("status bit not set by event");

	property p_gen_enable;
		@(posedge aclk) disable iff (!aresetn || port_reset)
		wr_fire && aw_addr_q == ext_cap_pkg::ERR_CTL_OFF && w_strb_q[0]
		|=> ecrc_gen_on == $past(w_data_q[ext_cap_pkg::GEN_EN_POS]);
	endproperty
	a_gen_enable: assert property (p_gen_enable)
		else $error("generation enable not applied");

	property p_serial_locked;
		@(posedge aclk) disable iff (!aresetn || port_reset)
		wr_fire && !cfg_unlock |=> $stable(serial_number_word_q[0])
			&& $stable(serial_number_word_q[1]) && $stable(ecrc_gen_capable_q);
	endproperty
	a_serial_locked: assert property (p_serial_locked)
		else $error("locked field changed");

	property p_first_capture;
		@(posedge aclk) disable iff (!aresetn)
		s_first_capture |=> log_held_q && first_error_pointer_q == $past(ue_bit)
			&& header_log_word_q[3] == $past(ue_hdr4);
	endproperty
	a_first_capture: assert property (p_first_capture)
		else $error("first error not captured");

	property p_log_holds;
		@(posedge aclk) disable iff (!aresetn)
		log_held_q && ue_valid |=> $stable(header_log_word_q[0])
			&& $stable(first_error_pointer_q);
	endproperty
	a_log_holds: assert property (p_log_holds)
		else $error("later error overwrote log");

	property p_read_answer;
		@(posedge aclk) disable iff (!aresetn)
		ar_take |=> rvalid && !arready;
	endproperty
	a_read_answer: assert property (p_read_answer)
		else $error("read not answered next cycle");

	property p_vc_header;
		@(posedge aclk) disable iff (!aresetn)
		ar_take && araddr == ext_cap_pkg::VC_CAP_OFF |=> rdata[19:0] == 20'h1_0002;
	endproperty
	a_vc_header: assert property (p_vc_header)
		else $error("channel header id wrong");
endmodule

// >>> corr_event_source.sv
/*
 * Event source model standing in for the port's link and transaction
 * layers: correctable event pulses and uncorrectable errors with header.
 * Assumes the bench calls one task at a time, all timed on aclk.
 */
`timescale 1ns/1ps
module corr_event_source (
	// clock
	input  wire logic   aclk,
	// correctable event lines
	output logic [5:0]  corr_evt,
	// uncorrectable error with header words
	output logic        ue_valid,
	output logic [4:0]  ue_bit,
	output logic [31:0] ue_hdr1,
	output logic [31:0] ue_hdr2,
	output logic [31:0] ue_hdr3,
	output logic [31:0] ue_hdr4
);
	// idle values: header lines carry a junk pattern between errors
	initial
	begin
		corr_evt = 6'h00;
		ue_valid = 1'b0;
		ue_bit   = 5'h1F;
		ue_hdr1  = 32'hA5A5_5A5A;
		ue_hdr2  = 32'h5A5A_A5A5;
		ue_hdr3  = 32'hA5A5_5A5A;
		ue_hdr4  = 32'h5A5A_A5A5;
	end
	// one-cycle pulse on the chosen correctable event lines
	task automatic pulse_corr(input logic [5:0] bits);
		@(posedge aclk);
		corr_evt <= bits;
		@(posedge aclk);
		corr_evt <= 6'h00;
	endtask
	// one-cycle uncorrectable error; header words valid only with it
	task automatic raise_ue(input logic [4:0] idx, input logic [31:0] base);
		@(posedge aclk);
		ue_valid <= 1'b1;
		ue_bit   <= idx;
		ue_hdr1  <= base;
		ue_hdr2  <= base + 32'h0000_0001;
		ue_hdr3  <= base + 32'h0000_0002;
		ue_hdr4  <= base + 32'h0000_0003;
		@(posedge aclk);
		ue_valid <= 1'b0;
		ue_bit   <= ~idx;
		ue_hdr1  <= ~base;
		ue_hdr2  <= ~base;
		ue_hdr3  <= ~base;
		ue_hdr4  <= ~base;
	endtask
endmodule

// >>> pcie_ext_cap_regs_tb_top.sv
/*
 * Self-checking bench for the extended-capability register bank.
 * Assumes an AXI4-Lite master built from tasks and the event model.
 */
`timescale 1ns/1ps
module pcie_ext_cap_regs_tb_top;
	logic        aclk, aresetn, port_reset, cfg_unlock;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata, corr_report_bits, ue_hdr1, ue_hdr2, ue_hdr3, ue_hdr4;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready, corr_report, ecrc_gen_on, ecrc_chk_on;
	logic [5:0]  corr_evt;
	logic        ue_valid;
	logic [4:0]  ue_bit;
	logic [31:0] d, acc;
	logic [1:0]  r;
	int          err_total, tests_run, cycle_count;
	int          evt_pos [6] = '{0, 6, 7, 8, 12, 13};
	logic [11:0] rst_addr [10] = '{12'h110, 12'h114, 12'h118, 12'h11C, 12'h120,
		12'h124, 12'h128, 12'h180, 12'h184, 12'h200};
	logic [31:0] rst_val [10] = '{32'h0000_0000, 32'h0000_2000, 32'h0000_00A0,
		32'h0000_0000, 32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
		32'h2001_0003, 32'h0000_0000, 32'h0001_0002};

	// design and event source
	ext_cap_regs u_dut (.aclk, .aresetn, .port_reset, .awaddr, .awvalid, .awready,
		.wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
		.arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .corr_evt, .ue_valid,
		.ue_bit, .ue_hdr1, .ue_hdr2, .ue_hdr3, .ue_hdr4, .cfg_unlock, .corr_report,
		.corr_report_bits, .ecrc_gen_on, .ecrc_chk_on);
	corr_event_source u_src (.aclk, .corr_evt, .ue_valid, .ue_bit, .ue_hdr1,
		.ue_hdr2, .ue_hdr3, .ue_hdr4);

	// 10 mhz clock
	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	// hang guard
	always @(posedge aclk)
	begin
		cycle_count <= cycle_count + 1;
		if (cycle_count == 20000)
		begin
			err_total = err_total + 1;
			end_of_test();
		end
	end

	// compare and count
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run = tests_run + 1;
		if (seen !== exp)
		begin
			err_total = err_total + 1;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// axi4-lite write: address and data offered together, each released when taken
	task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] resp,
		input logic [3:0] s = 4'hF);
		logic aw_done;
		logic w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= v;
		wstrb <= s;
		wvalid <= 1'b1;
		while (!(aw_done && w_done))
		begin
			@(posedge aclk);
			if (awvalid && awready === 1'b1)
			begin
				awvalid <= 1'b0;
				aw_done = 1'b1;
			end
			if (wvalid && wready === 1'b1)
			begin
				wvalid <= 1'b0;
				w_done = 1'b1;
			end
		end
		bready <= 1'b1;
		do @(posedge aclk); while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask

	// axi4-lite read
	task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] resp);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge aclk); while (rvalid !== 1'b1);
		v = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask

	// write then read back and compare
	task automatic wrc(input logic [11:0] a, input logic [31:0] v, input logic [31:0] exp);
		wr(a, v, r);
		check("write response", {30'h0, r}, 32'h0);
		rd(a, d, r);
		check("register readback", d, exp);
	endtask

	// gather reported bits over the cycles that follow an event pulse
	task automatic collect(output logic [31:0] a);
		a = '0;
		repeat (3)
		begin
			#1;
			if (corr_report === 1'b1)
				a = a | corr_report_bits;
			@(posedge aclk);
		end
	endtask

	// verdict
	task automatic end_of_test();
		if (err_total == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// main sequence
	initial
	begin
		{aresetn, port_reset, cfg_unlock, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, wstrb} = '0;
		{err_total, tests_run, cycle_count} = '0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		// reset values of every register except log control and the high serial number word
		for (int i = 0; i < 10; i++)
		begin
			rd(rst_addr[i], d, r);
			check("reset value", d, rst_val[i]);
		end
		wrc(12'h114, 32'hFFFF_FFFF, 32'h0000_31C1);
		// all masked: status sets, nothing reported
		u_src.pulse_corr(6'h3F);
		collect(acc);
		check("masked report", acc, 32'h0);
		rd(12'h110, d, r);
		check("status set", d, 32'h0000_31C1);
		wrc(12'h110, 32'hFFFF_FFFF, 32'h0);
		// each mask bit alone left open
		for (int i = 0; i < 6; i++)
		begin
			wrc(12'h114, 32'h0000_31C1 & ~(32'h1 << evt_pos[i]), 32'h0000_31C1 & ~(32'h1 << evt_pos[i]));
			u_src.pulse_corr(6'h3F);
			collect(acc);
			check("report bits", acc, 32'h1 << evt_pos[i]);
			wr(12'h110, 32'hFFFF_FFFF, r);
		end
		// byte strobe: only the low byte of the mask is cleared
		wr(12'h114, 32'h0000_0000, r, 4'h1);
		rd(12'h114, d, r);
		check("byte strobe mask", d, 32'h0000_1100);
		// error control while locked, then unlocked
		wrc(12'h118, 32'hFFFF_FFFF, 32'h0000_01E0);
		check("gen enable", {31'h0, ecrc_gen_on}, 32'h1);
		check("chk enable", {31'h0, ecrc_chk_on}, 32'h1);
		wrc(12'h118, 32'h0000_0000, 32'h0000_00A0);
		check("gen enable off", {31'h0, ecrc_gen_on}, 32'h0);
		check("chk enable off", {31'h0, ecrc_chk_on}, 32'h0);
		wrc(12'h184, 32'hDEAD_BEEF, 32'h0);
		cfg_unlock <= 1'b1;
		wrc(12'h118, 32'h0000_0000, 32'h0);
		wrc(12'h184, 32'hDEAD_BEEF, 32'hDEAD_BEEF);
		wrc(12'h188, 32'h1234_5678, 32'h1234_5678);
		wrc(12'h180, 32'h1230_0000, 32'h1231_0003);
		wrc(12'h200, 32'hFFFF_FFFF, 32'hFFF1_0002);
		cfg_unlock <= 1'b0;
		// port reset restores non-sticky lockable defaults, sticky fields survive
		@(posedge aclk);
		port_reset <= 1'b1;
		@(posedge aclk);
		port_reset <= 1'b0;
		for (int i = 7; i < 10; i++)
		begin
			rd(rst_addr[i], d, r);
			check("after port reset", d, (i == 8) ? 32'hDEAD_BEEF : rst_val[i]);
		end
		rd(12'h118, d, r);
		check("capable restored", d, 32'h0000_00A0);
		// first error capture, later errors ignored until release
		u_src.raise_ue(5'd17, 32'h1000_0000);
		u_src.raise_ue(5'd3, 32'h2000_0000);
		wrc(12'h11C, 32'hFFFF_FFFF, 32'h1000_0000);
		for (int i = 1; i < 4; i++)
		begin
			rd(12'h11C + 12'(4 * i), d, r);
			check("header log", d, 32'h1000_0000 + i);
		end
		rd(12'h118, d, r);
		check("first pointer", d, 32'h0000_00B1);
		wr(12'h130, 32'h0000_0001, r);
		u_src.raise_ue(5'd9, 32'h3000_0000);
		rd(12'h128, d, r);
		check("header log new", d, 32'h3000_0003);
		wrc(12'h118, 32'h0000_001F, 32'h0000_00A9);
		// unmapped and unaligned places
		rd(12'h104, d, r);
		check("unmapped data", d, 32'h0);
		check("unmapped read resp", {30'h0, r}, 32'h2);
		rd(12'h115, d, r);
		check("unaligned resp", {30'h0, r}, 32'h2);
		wr(12'h300, 32'hFFFF_FFFF, r);
		check("unmapped write resp", {30'h0, r}, 32'h2);
		// power-on reset restores sticky fields to their reset values
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rd(12'h184, d, r);
		check("serial after power reset", d, 32'h0);
		rd(12'h114, d, r);
		check("mask after power reset", d, 32'h0000_2000);
		end_of_test();
	end
endmodule
